// ---- src/tcss_pkg.sv ----
`default_nettype none
package tcss_pkg;

  // ---------------------------------------------------------------
  // parameter addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] TCSS_SMOOTH_ADDR = 16'h010E;
  localparam logic [15:0] TCSS_FULL_SCALE_ADDR = 16'h0152;
  localparam logic [15:0] TCSS_SMOOTH_RST = 16'h0000;
  localparam logic [15:0] TCSS_FULL_SCALE_RST = 16'h0064;
  localparam logic [15:0] TCSS_SMOOTH_MAX = 16'h03E8;
  localparam logic [15:0] TCSS_FULL_SCALE_MAX = 16'h03E8;
  localparam logic [15:0] TCSS_READ_ZERO = 16'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int TCSS_CLK_HZ = 25_000_000;
  localparam int TCSS_MS_PER_S = 1000;
  localparam int TCSS_CYC_PER_MS = TCSS_CLK_HZ / TCSS_MS_PER_S;
  localparam int TCSS_FILT_FRAC = 10;
  localparam logic [31:0] TCSS_FILT_STEP = 32'h0000_0400;

  // ---------------------------------------------------------------
  // scaling: command in tenths of a percent of rated torque
  // ---------------------------------------------------------------
  localparam int TCSS_VOLT_DIV = 10;
  localparam int TCSS_MV_PER_V = 1000;
  localparam int TCSS_TENTHS = 10;
  localparam int TCSS_SCALE_DIV = TCSS_MV_PER_V * TCSS_VOLT_DIV / TCSS_TENTHS;
  localparam logic signed [15:0] TCSS_ANALOG_MAX_MV = 16'sh2710;
  localparam logic signed [15:0] TCSS_PRESET_MAX_PCT = 16'sh012C;
  localparam logic signed [15:0] TCSS_CMD_MAX = 16'sh7FFF;
  localparam logic signed [15:0] TCSS_ZERO_CMD = 16'sh0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TCSS_MODE_TORQUE = 2'b00,
    TCSS_MODE_TORQUE_ZERO = 2'b01,
    TCSS_MODE_POSITION = 2'b10,
    TCSS_MODE_SPEED = 2'b11
  } tcss_mode_type;

  typedef enum logic [1:0] {
    TCSS_SRC_ANALOG = 2'b00,
    TCSS_SRC_PRESET_ONE = 2'b01,
    TCSS_SRC_PRESET_TWO = 2'b10,
    TCSS_SRC_PRESET_THREE = 2'b11
  } tcss_select_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tcss_param_req_type;

endpackage
`default_nettype wire

// ---- src/tcss_lowpass.sv ----
`timescale 1ns/10ps
`default_nettype none
module tcss_lowpass
  import tcss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] tau_ms,
  input wire logic signed [15:0] cmd_in,
  output logic signed [15:0] cmd_out_q
);

  // ---------------------------------------------------------------
  // step pacing: 1024 steps of 1/1024 per time constant
  // ---------------------------------------------------------------
  logic [31:0] period;
  logic [31:0] phase_q;
  logic [31:0] phase_sum;
  logic step;
  logic signed [25:0] acc_q;
  logic signed [26:0] diff;

  assign period = 32'(tau_ms) * 32'(TCSS_CYC_PER_MS);
  assign phase_sum = phase_q + TCSS_FILT_STEP;
  assign step = (phase_sum >= period);
  assign diff = 27'($signed({cmd_in, 10'b0})) - 27'(acc_q);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_q <= 32'h0000_0000;
    end else if (tau_ms == 16'h0000) begin
      phase_q <= 32'h0000_0000;
    end else if (step) begin
      // a shortened constant may leave the phase beyond one period
      if (phase_sum - period >= period) begin
        phase_q <= 32'h0000_0000;
      end else begin
        phase_q <= phase_sum - period;
      end
    end else begin
      phase_q <= phase_sum;
    end
  end

  // ---------------------------------------------------------------
  // first order accumulator
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_q <= 26'sh000_0000;
    end else if (tau_ms == 16'h0000) begin
      acc_q <= {cmd_in, 10'b0};
    end else if (step) begin
      acc_q <= acc_q + 26'(diff >>> TCSS_FILT_FRAC);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_out_q <= TCSS_ZERO_CMD;
    end else begin
      cmd_out_q <= acc_q[25:10];
    end
  end

  property p_bypass;
    @(posedge ref_clk) disable iff (rst)
    (tau_ms == 16'h0000) |-> ##2 (cmd_out_q == $past(cmd_in, 2));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("zero time constant does not pass command through");

  property p_no_reverse;
    @(posedge ref_clk) disable iff (rst)
    (tau_ms != 16'h0000 && $signed(acc_q[25:10]) < cmd_in && $stable(cmd_in))
      |=> (acc_q >= $past(acc_q));
  endproperty
  a_no_reverse: assert property (p_no_reverse)
    else $error("smoothed command moves away from its target");

endmodule
`default_nettype wire

// ---- src/tcss_torque_path.sv ----
`timescale 1ns/10ps
`default_nettype none
module tcss_torque_path
  import tcss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire tcss_param_req_type param_req,
  output logic [15:0] param_rdata_q,
  output logic param_ack_q,
  output logic param_err_q,
  input wire tcss_mode_type control_mode_param,
  input wire logic servo_on,
  input wire logic torque_select_bit0,
  input wire logic torque_select_bit1,
  input wire logic signed [15:0] analog_ref_mv,
  input wire logic signed [15:0] torque_preset_one,
  input wire logic signed [15:0] torque_preset_two,
  input wire logic signed [15:0] torque_preset_three,
  output logic signed [15:0] torque_command_q,
  output logic signed [15:0] torque_limit_q,
  output logic limit_active_q,
  output logic [1:0] select_code_q
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic signed [15:0] preset_scale(
    input logic signed [15:0] pct
  );
    logic signed [15:0] lim;
    lim = pct;
    if (lim > TCSS_PRESET_MAX_PCT) begin
      lim = TCSS_PRESET_MAX_PCT;
    end else if (lim < -TCSS_PRESET_MAX_PCT) begin
      lim = -TCSS_PRESET_MAX_PCT;
    end
    preset_scale = 16'(lim * 16'sd10);
  endfunction

  function automatic logic signed [15:0] analog_scale(
    input logic signed [15:0] mv,
    input logic [15:0] full_scale
  );
    logic signed [15:0] v;
    logic signed [33:0] prod;
    v = mv;
    if (v > TCSS_ANALOG_MAX_MV) begin
      v = TCSS_ANALOG_MAX_MV;
    end else if (v < -TCSS_ANALOG_MAX_MV) begin
      v = -TCSS_ANALOG_MAX_MV;
    end
    prod = 34'(v) * 34'($signed({1'b0, full_scale}));
    analog_scale = 16'(prod / 34'(TCSS_SCALE_DIV));
  endfunction

  function automatic logic signed [15:0] preset_pick(
    input logic [1:0] code,
    input logic signed [15:0] p1,
    input logic signed [15:0] p2,
    input logic signed [15:0] p3
  );
    case (code)
      TCSS_SRC_PRESET_ONE: preset_pick = preset_scale(p1);
      TCSS_SRC_PRESET_TWO: preset_pick = preset_scale(p2);
      default: preset_pick = preset_scale(p3);
    endcase
  endfunction

  // ---------------------------------------------------------------
  // parameter port
  // ---------------------------------------------------------------
  logic [15:0] smoothing_q;
  logic [15:0] full_scale_q;
  logic hit_smooth;
  logic hit_full;

  assign hit_smooth = (param_req.addr == TCSS_SMOOTH_ADDR);
  assign hit_full = (param_req.addr == TCSS_FULL_SCALE_ADDR);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      smoothing_q <= TCSS_SMOOTH_RST;
    end else if (param_req.wr && hit_smooth &&
                 param_req.wdata <= TCSS_SMOOTH_MAX) begin
      smoothing_q <= param_req.wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      full_scale_q <= TCSS_FULL_SCALE_RST;
    end else if (param_req.wr && hit_full &&
                 param_req.wdata <= TCSS_FULL_SCALE_MAX) begin
      full_scale_q <= param_req.wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      param_ack_q <= 1'b0;
      param_err_q <= 1'b0;
      param_rdata_q <= TCSS_READ_ZERO;
    end else begin
      param_ack_q <= param_req.wr || param_req.rd;
      param_err_q <= 1'b0;
      param_rdata_q <= TCSS_READ_ZERO;
      if (param_req.wr) begin
        if (hit_smooth) begin
          param_err_q <= (param_req.wdata > TCSS_SMOOTH_MAX);
        end else if (hit_full) begin
          param_err_q <= (param_req.wdata > TCSS_FULL_SCALE_MAX);
        end else begin
          param_err_q <= 1'b1;
        end
      end else if (param_req.rd) begin
        if (hit_smooth) begin
          param_rdata_q <= smoothing_q;
        end else if (hit_full) begin
          param_rdata_q <= full_scale_q;
        end else begin
          param_err_q <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // command source selection
  // ---------------------------------------------------------------
  logic [1:0] sel;
  logic [1:0] sel_q;
  logic sel_change;
  logic servo_on_q;
  logic servo_rise;
  logic signed [15:0] preset_hold_q;
  logic signed [15:0] raw_cmd_d;
  logic signed [15:0] raw_cmd_q;

  assign sel = {torque_select_bit1, torque_select_bit0};
  assign sel_change = (sel != sel_q);
  assign servo_rise = servo_on && !servo_on_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_q <= 2'b00;
      servo_on_q <= 1'b0;
    end else begin
      sel_q <= sel;
      servo_on_q <= servo_on;
    end
  end

  // a preset is captured when the code changes or servo comes on
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      preset_hold_q <= TCSS_ZERO_CMD;
    end else if (sel_change || servo_rise) begin
      preset_hold_q <= preset_pick(sel, torque_preset_one,
                                   torque_preset_two, torque_preset_three);
    end
  end

  always_comb begin
    raw_cmd_d = TCSS_ZERO_CMD;
    if (!servo_on_q) begin
      raw_cmd_d = TCSS_ZERO_CMD;
    end else if (sel_q != TCSS_SRC_ANALOG) begin
      raw_cmd_d = preset_hold_q;
    end else if (control_mode_param == TCSS_MODE_TORQUE_ZERO) begin
      raw_cmd_d = TCSS_ZERO_CMD;
    end else begin
      raw_cmd_d = analog_scale(analog_ref_mv, full_scale_q);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      raw_cmd_q <= TCSS_ZERO_CMD;
    end else begin
      raw_cmd_q <= raw_cmd_d;
    end
  end

  // ---------------------------------------------------------------
  // smoothing and routing
  // ---------------------------------------------------------------
  logic signed [15:0] filt;
  logic limit_mode;

  tcss_lowpass u_lowpass (
    .ref_clk(ref_clk),
    .rst(rst),
    .tau_ms(smoothing_q),
    .cmd_in(raw_cmd_q),
    .cmd_out_q(filt)
  );

  assign limit_mode = (control_mode_param == TCSS_MODE_POSITION) ||
                      (control_mode_param == TCSS_MODE_SPEED);

  // current loop takes this with fixed internal gains only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      torque_command_q <= TCSS_ZERO_CMD;
      torque_limit_q <= TCSS_CMD_MAX;
      limit_active_q <= 1'b0;
    end else if (limit_mode) begin
      torque_command_q <= TCSS_ZERO_CMD;
      torque_limit_q <= filt;
      limit_active_q <= 1'b1;
    end else begin
      torque_command_q <= filt;
      torque_limit_q <= TCSS_CMD_MAX;
      limit_active_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      select_code_q <= 2'b00;
    end else begin
      select_code_q <= sel_q;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_zero_mode;
    @(posedge ref_clk) disable iff (rst)
    (servo_on_q && sel_q == 2'b00 &&
     control_mode_param == TCSS_MODE_TORQUE_ZERO) |=> (raw_cmd_q == 16'sh0);
  endproperty
  a_zero_mode: assert property (p_zero_mode)
    else $error("zero-command mode gives nonzero command");

  property p_analog;
    @(posedge ref_clk) disable iff (rst)
    (servo_on_q && sel_q == 2'b00 &&
     control_mode_param == TCSS_MODE_TORQUE)
      |=> (raw_cmd_q == analog_scale($past(analog_ref_mv),
                                     $past(full_scale_q)));
  endproperty
  a_analog: assert property (p_analog)
    else $error("analog command not scaled from reference");

  property p_preset_one;
    @(posedge ref_clk) disable iff (rst)
    (servo_on_q && servo_on && sel != sel_q && sel == 2'b01)
      |-> ##2 (raw_cmd_q == preset_scale($past(torque_preset_one, 2)));
  endproperty
  a_preset_one: assert property (p_preset_one)
    else $error("first preset not taken after select change");

  property p_servo_off;
    @(posedge ref_clk) disable iff (rst)
    (!servo_on_q) |=> (raw_cmd_q == 16'sh0);
  endproperty
  a_servo_off: assert property (p_servo_off)
    else $error("command present without servo-on");

  property p_range;
    @(posedge ref_clk) disable iff (rst)
    (param_req.wr && hit_smooth && param_req.wdata > TCSS_SMOOTH_MAX)
      |=> (param_err_q && $stable(smoothing_q));
  endproperty
  a_range: assert property (p_range)
    else $error("out of range smoothing value accepted");

  property p_limit_route;
    @(posedge ref_clk) disable iff (rst)
    (limit_mode) |=> (limit_active_q && torque_command_q == 16'sh0 &&
                      torque_limit_q == $past(filt));
  endproperty
  a_limit_route: assert property (p_limit_route)
    else $error("limit not routed in position or speed mode");

  property p_torque_route;
    @(posedge ref_clk) disable iff (rst)
    (!limit_mode) |=> (!limit_active_q && torque_limit_q == TCSS_CMD_MAX &&
                       torque_command_q == $past(filt));
  endproperty
  a_torque_route: assert property (p_torque_route)
    else $error("command not routed in torque mode");

  property p_unmapped;
    @(posedge ref_clk) disable iff (rst)
    ((param_req.wr || param_req.rd) && !hit_smooth && !hit_full)
      |=> (param_ack_q && param_err_q);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("access to an unmapped address not refused");

endmodule
`default_nettype wire

// ---- verif/tcss_ctl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module tcss_ctl_model
  import tcss_pkg::*;
(
  input wire logic ref_clk,
  output var tcss_mode_type control_mode_param,
  output var logic servo_on,
  output var logic torque_select_bit0,
  output var logic torque_select_bit1,
  output var logic signed [15:0] analog_ref_mv,
  output var logic signed [15:0] torque_preset_one,
  output var logic signed [15:0] torque_preset_two,
  output var logic signed [15:0] torque_preset_three
);
  localparam logic signed [15:0] MV_LIM = 16'sh2710;

  initial begin
    control_mode_param = TCSS_MODE_TORQUE;
    servo_on = 1'b0;
    torque_select_bit0 = 1'b0;
    torque_select_bit1 = 1'b0;
    analog_ref_mv = 16'sh0000;
    torque_preset_one = 16'sh0032;
    torque_preset_two = 16'shFED4;
    // beyond the preset span on purpose to exercise clamping
    torque_preset_three = 16'sh0190;
  end

  // ---------------------------------------------------------------
  // one change of the controller outputs, just after a clock edge
  // ---------------------------------------------------------------
  task automatic drive(input tcss_mode_type m, input logic srv,
                       input logic [1:0] sel, input logic signed [15:0] mv);
    @(posedge ref_clk);
    #1;
    control_mode_param = m;
    servo_on = srv;
    // contacts stay open until servo-on
    torque_select_bit0 = srv & sel[0];
    torque_select_bit1 = srv & sel[1];
    if (mv > MV_LIM) begin
      analog_ref_mv = MV_LIM;
    end else if (mv < -MV_LIM) begin
      analog_ref_mv = -MV_LIM;
    end else begin
      analog_ref_mv = mv;
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/tcss_torque_path_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tcss_torque_path_tb
  import tcss_pkg::*;
;
  typedef struct packed {
    tcss_mode_type mode;
    logic [1:0] sel;
    logic signed [15:0] mv;
    logic [15:0] cmd;
    logic [15:0] lim;
    logic act;
  } tcss_row_type;

  logic ref_clk;
  logic rst;
  tcss_param_req_type param_req;
  logic [15:0] param_rdata_q;
  logic param_ack_q;
  logic param_err_q;
  tcss_mode_type control_mode_param;
  logic servo_on;
  logic torque_select_bit0;
  logic torque_select_bit1;
  logic signed [15:0] analog_ref_mv;
  logic signed [15:0] torque_preset_one;
  logic signed [15:0] torque_preset_two;
  logic signed [15:0] torque_preset_three;
  logic signed [15:0] torque_command_q;
  logic signed [15:0] torque_limit_q;
  logic limit_active_q;
  logic [1:0] select_code_q;
  int fails = 0;
  int check_count = 0;
  tcss_row_type r;
  logic signed [15:0] prev;
  logic [15:0] addrs [2] = '{TCSS_SMOOTH_ADDR, TCSS_FULL_SCALE_ADDR};
  tcss_row_type rows [10] = '{
    '{TCSS_MODE_TORQUE, 2'b00, 16'sh2710, 16'h03E8, 16'h7FFF, 1'b0},
    '{TCSS_MODE_TORQUE, 2'b00, 16'shFB2E, 16'hFF85, 16'h7FFF, 1'b0},
    '{TCSS_MODE_TORQUE_ZERO, 2'b00, 16'sh1B58, 16'h0000, 16'h7FFF, 1'b0},
    '{TCSS_MODE_TORQUE, 2'b01, 16'sh1388, 16'h01F4, 16'h7FFF, 1'b0},
    '{TCSS_MODE_TORQUE, 2'b10, 16'sh1388, 16'hF448, 16'h7FFF, 1'b0},
    '{TCSS_MODE_TORQUE, 2'b11, 16'sh1388, 16'h0BB8, 16'h7FFF, 1'b0},
    '{TCSS_MODE_POSITION, 2'b00, 16'sh1388, 16'h0000, 16'h01F4, 1'b1},
    '{TCSS_MODE_SPEED, 2'b10, 16'sh0000, 16'h0000, 16'hF448, 1'b1},
    '{TCSS_MODE_TORQUE_ZERO, 2'b01, 16'sh0000, 16'h01F4, 16'h7FFF, 1'b0},
    '{TCSS_MODE_SPEED, 2'b00, 16'shEC78, 16'h0000, 16'hFE0C, 1'b1}
  };

  tcss_ctl_model ctl (
    .ref_clk(ref_clk), .control_mode_param(control_mode_param),
    .servo_on(servo_on), .torque_select_bit0(torque_select_bit0),
    .torque_select_bit1(torque_select_bit1), .analog_ref_mv(analog_ref_mv),
    .torque_preset_one(torque_preset_one),
    .torque_preset_two(torque_preset_two),
    .torque_preset_three(torque_preset_three)
  );

  tcss_torque_path DUT (
    .ref_clk(ref_clk), .rst(rst), .param_req(param_req),
    .param_rdata_q(param_rdata_q), .param_ack_q(param_ack_q),
    .param_err_q(param_err_q), .control_mode_param(control_mode_param),
    .servo_on(servo_on), .torque_select_bit0(torque_select_bit0),
    .torque_select_bit1(torque_select_bit1), .analog_ref_mv(analog_ref_mv),
    .torque_preset_one(torque_preset_one),
    .torque_preset_two(torque_preset_two),
    .torque_preset_three(torque_preset_three),
    .torque_command_q(torque_command_q), .torque_limit_q(torque_limit_q),
    .limit_active_q(limit_active_q), .select_code_q(select_code_q)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic check_below(input string name, input logic signed [15:0] lo,
                             input logic signed [15:0] hi);
    check(name, 16'(lo < hi), 16'h0001);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic access(input logic wr, input logic [15:0] addr,
                        input logic [15:0] wdata, input logic [15:0] exp_rd,
                        input logic exp_err);
    @(posedge ref_clk);
    #1;
    param_req = '{addr: addr, wdata: wdata, wr: wr, rd: ~wr};
    wait_cyc(1);
    param_req = '0;
    check("ack", {15'h0000, param_ack_q}, 16'h0001);
    check("err", {15'h0000, param_err_q}, {15'h0000, exp_err});
    if (!wr) begin
      check("rdata", param_rdata_q, exp_rd);
    end
  endtask

  task automatic expect_out(input logic [15:0] cmd, input logic [15:0] lim,
                            input logic act);
    check("command", torque_command_q, cmd);
    check("limit", torque_limit_q, lim);
    check("active", {15'h0000, limit_active_q}, {15'h0000, act});
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    param_req = '0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    expect_out(16'h0000, 16'h7FFF, 1'b0);
    access(1'b0, TCSS_SMOOTH_ADDR, 16'h0000, 16'h0000, 1'b0);
    access(1'b0, TCSS_FULL_SCALE_ADDR, 16'h0000, 16'h0064, 1'b0);
    foreach (rows[i]) begin
      r = rows[i];
      ctl.drive(r.mode, 1'b1, r.sel, r.mv);
      wait_cyc(8);
      expect_out(r.cmd, r.lim, r.act);
      check("sel", {14'h0000, select_code_q}, {14'h0000, r.sel});
    end
    ctl.drive(TCSS_MODE_TORQUE, 1'b1, 2'b00, 16'sh0000);
    wait_cyc(8);
    ctl.drive(TCSS_MODE_TORQUE, 1'b1, 2'b01, 16'sh0000);
    wait_cyc(4);
    check("old cmd", torque_command_q, 16'h0000);
    wait_cyc(1);
    check("new cmd", torque_command_q, 16'h01F4);
    ctl.drive(TCSS_MODE_TORQUE, 1'b0, 2'b01, 16'sh2710);
    wait_cyc(8);
    check("servo off", torque_command_q, 16'h0000);
    ctl.drive(TCSS_MODE_TORQUE, 1'b1, 2'b01, 16'sh2710);
    wait_cyc(8);
    check("servo on", torque_command_q, 16'h01F4);
    access(1'b1, TCSS_FULL_SCALE_ADDR, 16'h00C8, 16'h0000, 1'b0);
    access(1'b1, TCSS_FULL_SCALE_ADDR, 16'h03E9, 16'h0000, 1'b1);
    access(1'b0, TCSS_FULL_SCALE_ADDR, 16'h0000, 16'h00C8, 1'b0);
    ctl.drive(TCSS_MODE_TORQUE, 1'b1, 2'b00, 16'sh2710);
    wait_cyc(8);
    check("fs 200", torque_command_q, 16'h07D0);
    foreach (addrs[i]) begin
      access(1'b1, addrs[i], 16'h03E9, 16'h0000, 1'b1);
      access(1'b1, addrs[i], 16'h03E8, 16'h0000, 1'b0);
      access(1'b0, addrs[i], 16'h0000, 16'h03E8, 1'b0);
    end
    access(1'b0, 16'h0153, 16'h0000, 16'h0000, 1'b1);
    access(1'b1, 16'h010F, 16'h0001, 16'h0000, 1'b1);
    access(1'b1, TCSS_SMOOTH_ADDR, 16'h0000, 16'h0000, 1'b0);
    wait_cyc(8);
    check("fs 1000", torque_command_q, 16'h2710);
    access(1'b1, TCSS_FULL_SCALE_ADDR, 16'h0064, 16'h0000, 1'b0);
    ctl.drive(TCSS_MODE_TORQUE, 1'b1, 2'b00, 16'sh0000);
    wait_cyc(8);
    access(1'b1, TCSS_SMOOTH_ADDR, 16'h0001, 16'h0000, 1'b0);
    ctl.drive(TCSS_MODE_TORQUE, 1'b1, 2'b00, 16'sh2710);
    wait_cyc(100);
    check_below("slow", torque_command_q, 16'sh0033);
    wait_cyc(24900);
    check_below("tau lo", 16'sh0226, torque_command_q);
    check_below("tau hi", torque_command_q, 16'sh02D0);
    prev = torque_command_q;
    ctl.drive(TCSS_MODE_TORQUE, 1'b1, 2'b00, 16'shD8F0);
    wait_cyc(100);
    check_below("fall", torque_command_q, prev);
    // reset again mid-run: outputs and settings return to defaults
    rst = 1'b1;
    wait_cyc(2);
    rst = 1'b0;
    expect_out(16'h0000, 16'h7FFF, 1'b0);
    access(1'b0, TCSS_SMOOTH_ADDR, 16'h0000, 16'h0000, 1'b0);
    access(1'b0, TCSS_FULL_SCALE_ADDR, 16'h0000, 16'h0064, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
